/* rtl/exec_pkg.sv */
// constants, opcodes and register map for the transfer/bit/flag execution unit
package exec_pkg;

   // register bus geometry
   localparam int         AXI_AW       = 8;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   // register byte offsets
   localparam logic [7:0] CMD_OFS      = 8'h00;
   localparam logic [7:0] STATUS_OFS   = 8'h04;
   localparam logic [7:0] FLAGS_OFS    = 8'h08;
   localparam logic [7:0] ZPTR_OFS     = 8'h0C;
   localparam logic [7:0] SPTR_OFS     = 8'h10;
   localparam logic [7:0] RFACC_OFS    = 8'h14;

   // command word and register-access word field positions
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_RD_LSB   = 8;
   localparam int CMD_RR_LSB   = 16;
   localparam int CMD_BIT_LSB  = 21;
   localparam int CMD_IO_LSB   = 24;
   localparam int RFACC_DAT_LSB = 8;
   localparam int RFACC_WE_BIT  = 16;

   // status flag positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // values after reset
   localparam logic [7:0]  FLAGS_RST = 8'h00;
   localparam logic [15:0] ZPTR_RST  = 16'h0000;
   localparam logic [15:0] SPTR_RST  = 16'h0FFF;
   localparam logic [31:0] CMD_RST   = 32'h0000_0000;

   // opcodes; 6'h20..6'h27 force flag op[2:0] to one, 6'h28..6'h2F to zero
   localparam logic [5:0] OP_NOP   = 6'h00;
   localparam logic [5:0] OP_IN    = 6'h01;
   localparam logic [5:0] OP_OUT   = 6'h02;
   localparam logic [5:0] OP_PUSH  = 6'h03;
   localparam logic [5:0] OP_POP   = 6'h04;
   localparam logic [5:0] OP_EXCH  = 6'h05;
   localparam logic [5:0] OP_LOR   = 6'h06;
   localparam logic [5:0] OP_LANDN = 6'h07;
   localparam logic [5:0] OP_LXOR  = 6'h08;
   localparam logic [5:0] OP_SLL   = 6'h09;
   localparam logic [5:0] OP_SRL   = 6'h0A;
   localparam logic [5:0] OP_RLC   = 6'h0B;
   localparam logic [5:0] OP_RRC   = 6'h0C;
   localparam logic [5:0] OP_SRA   = 6'h0D;
   localparam logic [5:0] OP_NIB   = 6'h0E;
   localparam logic [5:0] OP_FONE  = 6'h0F;
   localparam logic [5:0] OP_FZERO = 6'h10;
   localparam logic [5:0] OP_IOHI  = 6'h11;
   localparam logic [5:0] OP_IOLO  = 6'h12;
   localparam logic [5:0] OP_TSTO  = 6'h13;
   localparam logic [5:0] OP_TLD   = 6'h14;
   localparam logic [5:0] OP_BRK   = 6'h15;
   localparam logic [5:0] OP_SLP   = 6'h16;
   localparam logic [5:0] OP_WDOG  = 6'h17;
   localparam logic [1:0] OP_DFLAG_HI = 2'h2;

   // execution sequencer states, gray along idle-exec-mem-extra
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_MEM  = 2'b11,
      ST_XTRA = 2'b10
   } state_e;

endpackage

/* rtl/exec_regfile.sv */
// working register file with registered read ports
`timescale 1ns/10ps
`default_nettype none
module exec_regfile #(
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   input  wire logic          aclk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [7:0]    wdata,
   input  wire logic [AW-1:0] raddr_a,
   output logic      [7:0]    rdata_a,
   input  wire logic [AW-1:0] raddr_b,
   output logic      [7:0]    rdata_b
);
   logic [7:0] mem [DEPTH];

   // write port; contents are undefined until software loads them
   always_ff @(posedge aclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // read data come out of registers, one cycle after the address
   always_ff @(posedge aclk) begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
   end
endmodule // exec_regfile
`default_nettype wire

/* rtl/exec_alu.sv */
// combinational bit, shift, flag and atomic-merge datapath
`timescale 1ns/10ps
`default_nettype none
module exec_alu import exec_pkg::*; (
   input  wire logic [5:0] op,
   input  wire logic [7:0] a,
   input  wire logic [7:0] m,
   input  wire logic [2:0] sel,
   input  wire logic [7:0] flags_in,
   output logic      [7:0] res,
   output logic      [7:0] flags_out,
   output logic      [7:0] mem_out
);
   // one case per operation or shift family; flags not named by an operation pass through
   always_comb begin
      res       = a;
      flags_out = flags_in;
      mem_out   = m;
      case (op)
         OP_SLL, OP_RLC: begin
            res = {a[6:0], (op == OP_RLC) ? flags_in[FLAG_C] : 1'b0};
            flags_out[FLAG_C] = a[7];
            flags_out[FLAG_H] = a[3];
            flags_out[FLAG_N] = res[7];
            flags_out[FLAG_V] = res[7] ^ a[7];
            flags_out[FLAG_Z] = (res == 8'h00);
         end
         OP_SRL, OP_RRC, OP_SRA: begin
            res = {(op == OP_RRC) ? flags_in[FLAG_C] : ((op == OP_SRA) ? a[7] : 1'b0), a[7:1]};
            flags_out[FLAG_C] = a[0];
            flags_out[FLAG_N] = res[7];
            flags_out[FLAG_V] = res[7] ^ a[0];
            flags_out[FLAG_Z] = (res == 8'h00);
         end
         OP_NIB:   res = {a[3:0], a[7:4]};
         OP_TLD:   res[sel] = flags_in[FLAG_T];
         OP_TSTO:  flags_out[FLAG_T] = a[sel];
         OP_FONE:  flags_out[sel] = 1'b1;
         OP_FZERO: flags_out[sel] = 1'b0;
         OP_IOHI:  res = m | (8'h01 << sel);
         OP_IOLO:  res = m & ~(8'h01 << sel);
         OP_EXCH: begin
            res     = m;
            mem_out = a;
         end
         OP_LOR: begin
            res     = m;
            mem_out = a | m;
         end
         OP_LANDN: begin
            res     = m;
            mem_out = ~a & m;
         end
         OP_LXOR: begin
            res     = m;
            mem_out = a ^ m;
         end
         default: begin
            // dedicated single-flag forms: carry..interrupt, overflow, half-carry, transfer
            if (op[5:4] == OP_DFLAG_HI) begin
               flags_out[op[2:0]] = ~op[3];
            end
         end
      endcase
   end
endmodule // exec_alu
`default_nettype wire

/* rtl/cpu_transfer_bit_flag_ops.sv */
// execution unit for transfer, stack, atomic, bit, flag and control operations
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module cpu_transfer_bit_flag_ops import exec_pkg::*; #(
   parameter int          RF_DEPTH         = 32,
   parameter logic [63:0] EXTRA_CYCLE_OPS  = 64'h0000_0000_0000_0000,
   parameter logic [15:0] SRAM_BASE        = 16'h2000,
   parameter logic [15:0] SRAM_TOP         = 16'h3FFF
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [AXI_AW-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   output logic                   bvalid,
   input  wire logic              bready,
   output logic      [1:0]        bresp,
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [AXI_AW-1:0] araddr,
   input  wire logic [2:0]        arprot,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic      [31:0]       rdata,
   output logic      [1:0]        rresp,
   output logic                   dmem_req,
   output logic                   dmem_we,
   output logic      [15:0]       dmem_addr,
   output logic      [7:0]        dmem_wdata,
   input  wire logic [7:0]        dmem_rdata,
   input  wire logic              dmem_ready,
   output logic                   io_req,
   output logic                   io_we,
   output logic      [5:0]        io_addr,
   output logic      [7:0]        io_wdata,
   input  wire logic [7:0]        io_rdata,
   output logic                   break_pulse,
   output logic                   sleep_pulse,
   output logic                   wdt_restart_pulse
);
   localparam int RF_AW = $clog2(RF_DEPTH);

   state_e            state_r;
   logic              aw_got_r;
   logic              w_got_r;
   logic [AXI_AW-1:0] waddr_r;
   logic [31:0]       wbuf_r;
   logic [3:0]        wstrb_r;
   logic [31:0]       cmd_r;
   logic [7:0]        flags_r;
   logic [15:0]       zptr_r;
   logic [15:0]       sptr_r;
   logic [4:0]        rf_sel_r;
   logic [7:0]        op_a_r;
   logic [7:0]        cyc_r;
   logic [7:0]        wa;
   logic [7:0]        ra;
   logic [31:0]       old_word;
   logic [31:0]       new_word;
   logic              wr_do;
   logic              wr_err;
   logic              wr_ok;
   logic              start;
   logic              busy;
   logic [5:0]        op;
   logic [2:0]        bsel;
   logic              rf_we;
   logic [RF_AW-1:0]  rf_waddr;
   logic [7:0]        rf_wdata;
   logic [RF_AW-1:0]  rf_raddr_a;
   logic [RF_AW-1:0]  rf_raddr_b;
   logic [7:0]        rf_a;
   logic [7:0]        rf_b;
   logic [7:0]        alu_a;
   logic [7:0]        alu_m;
   logic [7:0]        alu_res;
   logic [7:0]        alu_flags;
   logic [7:0]        alu_mem;
   logic              is_atomic;
   logic              mem_done;
   logic              in_sram;

   // byte-lane merge of a bus write into an existing register value
   function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ---------------- register bus, write side ----------------
   assign wa    = {waddr_r[AXI_AW-1:2], 2'b00};
   assign wr_do = aw_got_r && w_got_r && !bvalid;
   assign busy  = (state_r != ST_IDLE) || dmem_req;
   assign op    = cmd_r[CMD_OP_LSB +: 6];
   assign bsel  = cmd_r[CMD_BIT_LSB +: 3];

   // writable registers are refused while an instruction is in flight
   always_comb begin
      case (wa)
         CMD_OFS:   old_word = cmd_r;
         FLAGS_OFS: old_word = {24'h00_0000, flags_r};
         ZPTR_OFS:  old_word = {16'h0000, zptr_r};
         SPTR_OFS:  old_word = {16'h0000, sptr_r};
         RFACC_OFS: old_word = {27'h000_0000, rf_sel_r};
         default:   old_word = 32'h0000_0000;
      endcase
      wr_err = busy || !(wa == CMD_OFS || wa == FLAGS_OFS || wa == ZPTR_OFS ||
                         wa == SPTR_OFS || wa == RFACC_OFS);
   end
   assign new_word = merge_lanes(old_word, wbuf_r, wstrb_r);
   assign wr_ok    = wr_do && !wr_err;
   assign start    = wr_ok && (wa == CMD_OFS);

   // address channel: held until the paired data arrive
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready  <= 1'b0;
         aw_got_r <= 1'b0;
         waddr_r  <= '0;
      end else if (awvalid && awready) begin
         awready  <= 1'b0;
         aw_got_r <= 1'b1;
         waddr_r  <= awaddr;
      end else begin
         if (wr_do) begin
            aw_got_r <= 1'b0;
         end
         awready <= !aw_got_r || wr_do;
      end
   end

   // data channel, taken independently of the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready  <= 1'b0;
         w_got_r <= 1'b0;
         wbuf_r  <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (wvalid && wready) begin
         wready  <= 1'b0;
         w_got_r <= 1'b1;
         wbuf_r  <= wdata;
         wstrb_r <= wstrb;
      end else begin
         if (wr_do) begin
            w_got_r <= 1'b0;
         end
         wready <= !w_got_r || wr_do;
      end
   end

   // write response, one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (wr_do) begin
         bvalid <= 1'b1;
         bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ---------------- register bus, read side ----------------
   assign ra = {araddr[AXI_AW-1:2], 2'b00};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= RESP_OKAY;
         case (ra)
            CMD_OFS:    rdata <= cmd_r;
            STATUS_OFS: rdata <= {8'h00, cyc_r, 7'h00, busy, flags_r};
            FLAGS_OFS:  rdata <= {24'h00_0000, flags_r};
            ZPTR_OFS:   rdata <= {16'h0000, zptr_r};
            SPTR_OFS:   rdata <= {16'h0000, sptr_r};
            RFACC_OFS:  rdata <= {19'h0_0000, rf_sel_r, rf_a};
            default: begin
               rdata <= 32'h0000_0000;
               rresp <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // ---------------- software-visible state ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_r    <= CMD_RST;
         zptr_r   <= ZPTR_RST;
         rf_sel_r <= 5'h00;
      end else if (wr_ok) begin
         if (wa == CMD_OFS)   cmd_r    <= new_word;
         if (wa == ZPTR_OFS)  zptr_r   <= new_word[15:0];
         if (wa == RFACC_OFS) rf_sel_r <= new_word[4:0];
      end
   end

   // flags: software load when idle, otherwise result of the executing op
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_r <= FLAGS_RST;
      end else if (wr_ok && wa == FLAGS_OFS) begin
         flags_r <= new_word[7:0];
      end else if (state_r == ST_EXEC) begin
         flags_r <= alu_flags;
      end
   end

   // stack pointer moves down on push, up before a pop read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sptr_r <= SPTR_RST;
      end else if (wr_ok && wa == SPTR_OFS) begin
         sptr_r <= new_word[15:0];
      end else if (state_r == ST_EXEC && op == OP_PUSH) begin
         sptr_r <= sptr_r - 16'h0001;
      end else if (state_r == ST_EXEC && op == OP_POP) begin
         sptr_r <= sptr_r + 16'h0001;
      end
   end

   // ---------------- sequencer ----------------
   assign is_atomic = (op == OP_EXCH) || (op == OP_LOR) || (op == OP_LANDN) || (op == OP_LXOR);
   assign mem_done  = dmem_req && dmem_ready;
   assign in_sram   = (dmem_addr >= SRAM_BASE) && (dmem_addr <= SRAM_TOP);

   // one exec cycle for all ops; pop and atomics add a read cycle, stretched by a slow memory
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: if (start) state_r <= ST_EXEC;
            ST_EXEC: state_r <= (op == OP_POP || is_atomic) ? ST_MEM : ST_IDLE;
            ST_MEM: begin
               if (mem_done) begin
                  state_r <= (EXTRA_CYCLE_OPS[op] && in_sram) ? ST_XTRA : ST_IDLE;
               end
            end
            ST_XTRA: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // cycles spent by the last instruction, shown in the status word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cyc_r <= 8'h00;
      end else if (start) begin
         cyc_r <= 8'h00;
      end else if (state_r != ST_IDLE) begin
         cyc_r <= cyc_r + 8'h01;
      end
   end

   // rd operand kept for the atomic memory write after the memory read returns
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op_a_r <= 8'h00;
      end else if (state_r == ST_EXEC) begin
         op_a_r <= rf_a;
      end
   end

   // ---------------- datapath ----------------
   assign rf_raddr_a = start ? new_word[CMD_RD_LSB +: RF_AW] : rf_sel_r[RF_AW-1:0];
   assign rf_raddr_b = new_word[CMD_RR_LSB +: RF_AW];
   assign alu_a      = (state_r == ST_MEM) ? op_a_r : rf_a;
   assign alu_m      = (state_r == ST_MEM) ? dmem_rdata : io_rdata;

   exec_regfile #(
      .DEPTH (RF_DEPTH),
      .AW    (RF_AW)
   ) u_rf (
      .aclk    (aclk),
      .we      (rf_we),
      .waddr   (rf_waddr),
      .wdata   (rf_wdata),
      .raddr_a (rf_raddr_a),
      .rdata_a (rf_a),
      .raddr_b (rf_raddr_b),
      .rdata_b (rf_b)
   );

   exec_alu u_alu (
      .op        (op),
      .a         (alu_a),
      .m         (alu_m),
      .sel       (bsel),
      .flags_in  (flags_r),
      .res       (alu_res),
      .flags_out (alu_flags),
      .mem_out   (alu_mem)
   );

   // register write-back: exec result, returning memory byte, or software load
   always_comb begin
      rf_we    = 1'b0;
      rf_waddr = cmd_r[CMD_RD_LSB +: RF_AW];
      rf_wdata = alu_res;
      if (state_r == ST_EXEC && (op == OP_IN || op == OP_NIB || op == OP_TLD ||
                                 (op >= OP_SLL && op <= OP_SRA))) begin
         rf_we    = 1'b1;
         rf_wdata = (op == OP_IN) ? io_rdata : alu_res;
      end else if (state_r == ST_MEM && mem_done) begin
         rf_we    = 1'b1;
         rf_wdata = dmem_rdata;
      end else if (wr_ok && wa == RFACC_OFS && new_word[RFACC_WE_BIT]) begin
         rf_we    = 1'b1;
         rf_waddr = new_word[RF_AW-1:0];
         rf_wdata = new_word[RFACC_DAT_LSB +: 8];
      end
   end

   // data memory port: request stands until the memory answers ready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dmem_req   <= 1'b0;
         dmem_we    <= 1'b0;
         dmem_addr  <= 16'h0000;
         dmem_wdata <= 8'h00;
      end else begin
         if (mem_done) begin
            dmem_req <= 1'b0;
         end
         if (state_r == ST_EXEC && op == OP_PUSH) begin
            dmem_req   <= 1'b1;
            dmem_we    <= 1'b1;
            dmem_addr  <= sptr_r;
            dmem_wdata <= rf_b;
         end else if (state_r == ST_EXEC && op == OP_POP) begin
            dmem_req  <= 1'b1;
            dmem_we   <= 1'b0;
            dmem_addr <= sptr_r + 16'h0001;
         end else if (state_r == ST_EXEC && is_atomic) begin
            dmem_req  <= 1'b1;
            dmem_we   <= 1'b0;
            dmem_addr <= zptr_r;
         end else if (state_r == ST_MEM && mem_done && is_atomic) begin
            dmem_req   <= 1'b1;
            dmem_we    <= 1'b1;
            dmem_wdata <= alu_mem;
         end
      end
   end

   // i/o port: read strobe with the command, write strobe after the exec cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         io_req   <= 1'b0;
         io_we    <= 1'b0;
         io_addr  <= 6'h00;
         io_wdata <= 8'h00;
      end else begin
         io_req <= 1'b0;
         io_we  <= 1'b0;
         if (start) io_addr <= new_word[CMD_IO_LSB +: 6];
         if (start && (new_word[CMD_OP_LSB +: 6] == OP_IN || new_word[CMD_OP_LSB +: 6] == OP_IOHI ||
                       new_word[CMD_OP_LSB +: 6] == OP_IOLO)) begin
            io_req  <= 1'b1;
         end else if (state_r == ST_EXEC && (op == OP_OUT || op == OP_IOHI || op == OP_IOLO)) begin
            io_req   <= 1'b1;
            io_we    <= 1'b1;
            io_wdata <= (op == OP_OUT) ? rf_b : alu_res;
         end
      end
   end

   // control strobes handed to the debug, sleep and watchdog units
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         break_pulse       <= 1'b0;
         sleep_pulse       <= 1'b0;
         wdt_restart_pulse <= 1'b0;
      end else begin
         break_pulse       <= (state_r == ST_EXEC) && (op == OP_BRK);
         sleep_pulse       <= (state_r == ST_EXEC) && (op == OP_SLP);
         wdt_restart_pulse <= (state_r == ST_EXEC) && (op == OP_WDOG);
      end
   end
endmodule // cpu_transfer_bit_flag_ops
`default_nettype wire

/* verification/exec_chk_assertions.sv */
// handshake and pulse checks at the execution unit ports
`timescale 1ns/10ps
`default_nettype none
module exec_chk (
   input wire logic        aclk, aresetn, bvalid, bready, arvalid, arready, rvalid, rready,
   input wire logic        io_we, break_pulse, sleep_pulse, wdt_restart_pulse, dmem_req, dmem_ready,
   input wire logic [15:0] dmem_addr
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence rd_taken; arvalid && arready; endsequence
   // a stalled memory request must not wander while it waits
   sequence mem_wait; dmem_req && !dmem_ready; endsequence
   bresp_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("bvalid lost");
   rdata_hold_a: assert property (rvalid && !rready |=> rvalid) else $error("rvalid lost");
   read_answer_a: assert property (rd_taken |=> rvalid) else $error("read late");
   mem_hold_a: assert property (mem_wait |=> dmem_req && $stable(dmem_addr))
      else $error("mem moved");
   io_write_pulse_a: assert property (io_we |=> !io_we) else $error("io we long");
   break_pulse_a: assert property (break_pulse |=> !break_pulse) else $error("brk long");
   sleep_pulse_a: assert property (sleep_pulse |=> !sleep_pulse) else $error("slp long");
   wdt_pulse_a: assert property (wdt_restart_pulse |=> !wdt_restart_pulse) else $error("wdt long");
endmodule // exec_chk
bind cpu_transfer_bit_flag_ops exec_chk i_exec_chk (.*);
`default_nettype wire

/* verification/mem_io.sv */
// data memory and i/o space model facing the execution unit
`timescale 1ns/10ps
`default_nettype none
module mem_io (
   input wire logic        aclk, slow, dmem_req, dmem_we, io_req, io_we,
   input wire logic [15:0] dmem_addr,
   input wire logic [7:0]  dmem_wdata, io_wdata,
   input wire logic [5:0]  io_addr,
   output logic            dmem_ready,
   output logic [7:0]      dmem_rdata, io_rdata
);
   logic [7:0] mem [256];
   logic [7:0] io [64];
   logic       tgl = 1'b0;
   // slow mode answers every other cycle, like an external memory
   assign dmem_ready = dmem_req && (!slow || tgl);
   // idle lines show the inverse so a stale value never passes
   assign dmem_rdata = dmem_req ? mem[dmem_addr[7:0]] : ~mem[dmem_addr[7:0]];
   assign io_rdata = io_req ? io[io_addr] : ~io[io_addr];
   always @(posedge aclk) begin
      tgl <= !tgl;
      if (dmem_ready && dmem_we) mem[dmem_addr[7:0]] <= dmem_wdata;
      if (io_req && io_we) io[io_addr] <= io_wdata;
   end
endmodule // mem_io
`default_nettype wire

/* verification/cpu_transfer_bit_flag_ops_tb.sv */
// self-checking bench for the execution unit
`timescale 1ns/10ps
`default_nettype none
module cpu_transfer_bit_flag_ops_tb import exec_pkg::*;;
   logic        aclk = 0, aresetn = 0, slow = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, dmem_req, dmem_we, dmem_ready, io_req, io_we;
   logic        break_pulse, sleep_pulse, wdt_restart_pulse;
   logic [7:0]  awaddr = 0, araddr = 0, dmem_wdata, dmem_rdata, io_wdata, io_rdata;
   logic [31:0] wdata = 0, rdata, rd_v;
   logic [1:0]  bresp, rresp, resp;
   logic [15:0] dmem_addr;
   logic [5:0]  io_addr;
   int          n_errors = 0, cmp_count = 0, n_pls = 0;
   cpu_transfer_bit_flag_ops i_cpu_transfer_bit_flag_ops (.*, .wstrb(4'hF), .awprot(3'h0), .arprot(3'h0));
   mem_io i_mem_io (.*);
   initial forever #50 aclk = !aclk;
   always @(posedge aclk) n_pls <= n_pls + {break_pulse, sleep_pulse, wdt_restart_pulse};
   task automatic chk(input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ready is sampled mid-cycle so the decision never races the edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tk;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int k = 0; k < 40; k++) begin
         @(negedge aclk) {ta, tw, tk, resp} = {awready, wready, bvalid, bresp};
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tk && bready) begin
            bready <= 1'b0;
            return;
         end
         if (tk) bready <= 1'b1;
      end
      n_errors++;
      end_sim();
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta, tv;
      araddr <= a;
      arvalid <= 1'b1;
      for (int k = 0; k < 40; k++) begin
         @(negedge aclk) {ta, tv, resp, rd_v} = {arready, rvalid, rresp, rdata};
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tv && rready) begin
            rready <= 1'b0;
            return;
         end
         if (tv) rready <= 1'b1;
      end
      n_errors++;
      end_sim();
   endtask
   function automatic logic [31:0] cm(logic [5:0] op, logic [4:0] d, r, logic [2:0] b, logic [5:0] a);
      return {2'h0, a, b, r, 3'h0, d, 2'h0, op};
   endfunction
   task automatic setr(input logic [4:0] s, input logic [7:0] v);
      wr(RFACC_OFS, {15'h0000, 1'b1, v, 3'h0, s});
   endtask
   task automatic getr(input logic [4:0] s);
      wr(RFACC_OFS, {24'h00_0000, 3'h0, s});
      rd(RFACC_OFS);
   endtask
   // cyc of zero skips the cycle count, for stretched memory
   task automatic run(input logic [31:0] c, input logic [7:0] cyc);
      wr(CMD_OFS, c);
      for (int k = 0; k < 20; k++) begin
         rd(STATUS_OFS);
         if (rd_v[8] === 1'b0) begin
            if (cyc != 0) chk(rd_v[23:16], cyc);
            return;
         end
      end
      n_errors++;
      end_sim();
   endtask
   task automatic t_io();
      i_mem_io.io[5] = 8'hA5;
      i_mem_io.io[7] = 8'h0F;
      wr(FLAGS_OFS, 32'h0000_005A);
      run(cm(OP_IN, 3, 0, 0, 5), 1);
      run(cm(OP_OUT, 0, 3, 0, 6), 1);
      run(cm(OP_IOHI, 0, 0, 7, 7), 1);
      run(cm(OP_IOLO, 0, 0, 0, 7), 1);
      chk(i_mem_io.io[6], 8'hA5);
      chk(i_mem_io.io[7], 8'h8E);
      rd(FLAGS_OFS);
      chk(rd_v, 32'h0000_005A);
   endtask
   task automatic t_stack();
      wr(SPTR_OFS, 32'h0000_00FF);
      setr(4, 8'hC3);
      run(cm(OP_PUSH, 0, 4, 0, 0), 1);
      chk(i_mem_io.mem[8'hFF], 8'hC3);
      run(cm(OP_POP, 5, 0, 0, 0), 2);
      getr(5);
      chk(rd_v[7:0], 8'hC3);
   endtask
   task automatic t_atomic();
      logic [7:0] em [4] = '{8'h0F, 8'h3F, 8'h30, 8'h33};
      wr(ZPTR_OFS, 32'h0000_0010);
      for (int i = 0; i < 4; i++) begin
         i_mem_io.mem[8'h10] = 8'h3C;
         setr(6, 8'h0F);
         slow <= i[0];
         run(cm(OP_EXCH + i, 6, 0, 0, 0), i[0] ? 0 : 2);
         getr(6);
         chk(rd_v[7:0], 8'h3C);
         chk(i_mem_io.mem[8'h10], em[i]);
      end
      slow <= 1'b0;
   endtask
   task automatic t_shift();
      logic [7:0] v, r;
      logic c, co;
      for (int i = 0; i < 10; i++) begin
         v = i[0] ? 8'h01 : 8'h81;
         c = !i[0];
         case (i / 2)
            0: {co, r} = {v, 1'b0};
            1: {r, co} = {1'b0, v};
            2: {co, r} = {v, c};
            3: {r, co} = {c, v};
            default: {r, co} = {v[7], v};
         endcase
         wr(FLAGS_OFS, {24'h00_0000, 8'hD0 | c});
         setr(9, v);
         run(cm(OP_SLL + i / 2, 9, 0, 0, 0), 1);
         getr(9);
         chk(rd_v[7:0], r);
         rd(FLAGS_OFS);
         chk(rd_v[7:0] & 8'hDF, {4'hD, r[7] ^ co, r[7], r == 0, co});
      end
      run(cm(OP_NIB, 9, 0, 0, 0), 1);
      getr(9);
      chk(rd_v[7:0], {r[3:0], r[7:4]});
   endtask
   task automatic t_bits();
      logic [5:0] ops [4] = '{OP_FONE, 6'h28, 6'h20, OP_FZERO};
      for (int i = 0; i < 8; i++) begin
         wr(FLAGS_OFS, 32'h0000_0000);
         for (int j = 0; j < 4; j++) begin
            run(cm(ops[j] | ((j[0] ^ j[1]) ? i : 0), 0, 0, i, 0), 1);
            rd(FLAGS_OFS);
            chk(rd_v, j[0] ? 32'h0000_0000 : 32'h0000_0001 << i);
         end
      end
      setr(7, 8'h04);
      setr(8, 8'h00);
      run(cm(OP_TSTO, 7, 0, 2, 0), 1);
      run(cm(OP_TLD, 8, 0, 5, 0), 1);
      getr(8);
      chk(rd_v[7:0], 8'h20);
      foreach (ops[j]) run(cm(6'h00 + j * (j > 0) + (j > 0) * 6'h14, 0, 0, 0, 0), 1);
      chk(n_pls, 7);
      rd(FLAGS_OFS);
      chk(rd_v, 32'h0000_0040);
      rd(8'h40);
      chk(resp, RESP_SLVERR);
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_io();
      t_stack();
      t_atomic();
      t_shift();
      t_bits();
      end_sim();
   end
endmodule // cpu_transfer_bit_flag_ops_tb
`default_nettype wire
